// ===== core/acwd_device.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - top bit ignored, no behaviour change
// - host keeps bit 6 at zero
// - bit 5 one disables internal reference
// - bit 4 zero: single input, pin is reference
// - bit 4 one: two inputs, supply reference
// - host sets bit 5 in two-input mode
// - bit 3 picks input in two-input mode
// - host keeps bit 3 zero when single
// - host keeps bit 2 at zero
// - bits 1..0 select power mode
// - first eight rising edges captured, MSB first
// - each frame spans sixteen serial clocks
// - word is all zeros after power-up
// - four power policies, wake 5 us
module acwd_device (
  // Link
  acwd_link_if.dev              link,
  // Link-domain reset
  input  wire logic             rst,
  // Decoded configuration, link clock domain
  output logic                  ref_enabled,
  output logic                  two_inputs,
  output logic                  pin_is_scale,
  output logic                  pick_second,
  output acwd_pkg::acwd_pm_e    power_mode,
  output logic                  powered,
  output logic [7:0]            cfg_word
);
  import acwd_pkg::*;

  logic [CFG_W-1:0] shift_r, shift_nxt;
  logic [CFG_W-1:0] cfg_r,   cfg_nxt;
  logic [4:0]       cnt_r,   cnt_nxt;

  // The serial clock stands still while select is high, so the counter
  // cannot be cleared between frames; it wraps after the last rise instead
  always_comb begin
    shift_nxt = shift_r;
    cfg_nxt   = cfg_r;
    cnt_nxt   = cnt_r;
    if (link.cs_n) begin
      cnt_nxt = 5'h00;
    end else if (cnt_r < 5'(CFG_W)) begin
      shift_nxt = {shift_r[CFG_W-2:0], link.din};
      cnt_nxt   = cnt_r + 5'h01;
      if (cnt_r == 5'(CFG_W - 1)) begin
        cfg_nxt = {shift_r[CFG_W-2:0], link.din};
      end
    end else if (cnt_r < 5'(FRAME_CLKS - 1)) begin
      cnt_nxt = cnt_r + 5'h01;
    end else begin
      cnt_nxt = 5'h00;
    end
  end

  always_ff @(posedge link.sclk) begin
    if (rst) begin
      shift_r <= CFG_RESET;
      cfg_r   <= CFG_RESET;
      cnt_r   <= 5'h00;
    end else begin
      shift_r <= shift_nxt;
      cfg_r   <= cfg_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Bit 7 is never looked at; bits 6 and 2 only pass through to cfg_word
  assign cfg_word     = cfg_r;
  assign ref_enabled  = ~cfg_r[BIT_REF_OFF];
  assign two_inputs   = cfg_r[BIT_DUAL];
  assign pin_is_scale = ~cfg_r[BIT_DUAL];
  assign pick_second  = cfg_r[BIT_DUAL] & cfg_r[BIT_PICK];
  assign power_mode   = acwd_pm_decode(cfg_r[BIT_PM_HI:BIT_PM_LO]);

  // Only full-on ignores the pin; every other policy follows select
  always_comb begin
    case (power_mode)
      ACWD_PM_SELECT_GATED: powered = ~link.cs_n;
      ACWD_PM_FULL_ON:      powered = 1'b1;
      default:              powered = ~link.cs_n;
    endcase
  end
endmodule
`default_nettype wire

// ===== core/acwd_host.sv
`timescale 1ns/1ps
`default_nettype none
module acwd_host #(
  parameter int unsigned DIV = 2
) (
  // System
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Link
  acwd_link_if.host       link
);
  import acwd_pkg::*;

  typedef enum logic [1:0] {IDLE, LOW, HIGH, DONE} acwd_st_e;

  acwd_st_e   st_r, st_nxt;
  logic [7:0] word_r, word_nxt, last_r, last_nxt, rdata_nxt;
  logic [4:0] bit_r, bit_nxt;
  logic [7:0] div_r, div_nxt;
  logic       sclk_r, sclk_nxt, cs_n_r, cs_n_nxt, din_r, din_nxt;

  // Bits 6 and 2 forced low; bit 3 cleared unless two inputs
  function automatic logic [7:0] acwd_clean(input logic [7:0] w);
    logic [7:0] c;
    c = w;
    c[BIT_ZERO_HI] = 1'b0;
    c[BIT_ZERO_LO] = 1'b0;
    if (!w[BIT_DUAL]) c[BIT_PICK] = 1'b0;
    if (w[BIT_DUAL]) c[BIT_REF_OFF] = 1'b1;
    return c;
  endfunction

  always_comb begin
    st_nxt = st_r; word_nxt = word_r; last_nxt = last_r;
    bit_nxt = bit_r; div_nxt = div_r; sclk_nxt = sclk_r;
    cs_n_nxt = cs_n_r; din_nxt = din_r; rdata_nxt = 8'h00;
    if (rd) begin
      case (addr)
        REG_STATUS: rdata_nxt = {7'h00, st_r != IDLE};
        REG_LAST:   rdata_nxt = last_r;
        default:    rdata_nxt = 8'h00;
      endcase
    end
    div_nxt = (div_r == 8'(DIV - 1)) ? 8'h00 : div_r + 8'h01;
    case (st_r)
      IDLE: if (wr && addr == REG_CMD) begin
        word_nxt = acwd_clean(wdata);
        last_nxt = acwd_clean(wdata);
        cs_n_nxt = 1'b0; bit_nxt = 5'h00; div_nxt = 8'h00; st_nxt = LOW;
        din_nxt  = wdata[BIT_IGNORED];
      end
      LOW: if (div_r == 8'(DIV - 1)) begin
        sclk_nxt = 1'b1; st_nxt = HIGH;
      end
      HIGH: if (div_r == 8'(DIV - 1)) begin
        sclk_nxt = 1'b0;
        bit_nxt  = bit_r + 5'h01;
        word_nxt = {word_r[6:0], 1'b0};
        din_nxt  = word_r[6];
        st_nxt   = (bit_r == 5'(FRAME_CLKS - 1)) ? DONE : LOW;
      end
      DONE: begin
        cs_n_nxt = 1'b1; st_nxt = IDLE;
      end
      default: st_nxt = IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= IDLE; word_r <= 8'h00; last_r <= CFG_RESET; bit_r <= 5'h00;
      div_r <= 8'h00; sclk_r <= 1'b0; cs_n_r <= 1'b1; din_r <= 1'b0;
      rdata <= 8'h00;
    end else begin
      st_r <= st_nxt; word_r <= word_nxt; last_r <= last_nxt;
      bit_r <= bit_nxt; div_r <= div_nxt; sclk_r <= sclk_nxt;
      cs_n_r <= cs_n_nxt; din_r <= din_nxt; rdata <= rdata_nxt;
    end
  end

  assign link.sclk = sclk_r;
  assign link.cs_n = cs_n_r;
  assign link.din  = din_r;
endmodule
`default_nettype wire

// ===== inc/acwd_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface acwd_link_if;
  logic sclk;
  logic cs_n;
  logic din;

  modport host (
    output sclk,
    output cs_n,
    output din
  );

  modport dev (
    input sclk,
    input cs_n,
    input din
  );
endinterface
`default_nettype wire

// ===== inc/acwd_pkg.sv
package acwd_pkg;

  // Configuration word layout, MSB first on the wire
  localparam int unsigned CFG_W        = 8;
  localparam int unsigned FRAME_CLKS   = 16;
  localparam int unsigned BIT_IGNORED  = 7;
  localparam int unsigned BIT_ZERO_HI  = 6;
  localparam int unsigned BIT_REF_OFF  = 5;
  localparam int unsigned BIT_DUAL     = 4;
  localparam int unsigned BIT_PICK     = 3;
  localparam int unsigned BIT_ZERO_LO  = 2;
  localparam int unsigned BIT_PM_HI    = 1;
  localparam int unsigned BIT_PM_LO    = 0;
  localparam logic [7:0]  CFG_RESET    = 8'h00;

  // Wake time after full shutdown, in ns
  localparam int unsigned WAKE_NS      = 5000;
  localparam int unsigned LINK_NS      = 30;

  // Host register map (word offsets on the plain port)
  localparam logic [1:0] REG_CMD       = 2'h0;
  localparam logic [1:0] REG_STATUS    = 2'h1;
  localparam logic [1:0] REG_LAST      = 2'h2;

  typedef enum logic [1:0] {
    ACWD_PM_SELECT_GATED,
    ACWD_PM_FULL_ON,
    ACWD_PM_SHUTDOWN_AFTER,
    ACWD_PM_STANDBY_AFTER
  } acwd_pm_e;

  function automatic acwd_pm_e acwd_pm_decode(input logic [1:0] f);
    case (f)
      2'h0:    return ACWD_PM_SELECT_GATED;
      2'h1:    return ACWD_PM_FULL_ON;
      2'h2:    return ACWD_PM_SHUTDOWN_AFTER;
      default: return ACWD_PM_STANDBY_AFTER;
    endcase
  endfunction

endpackage

// ===== test/acwd_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module acwd_monitor (
  // Clocks and resets
  input wire logic               ref_clk,
  input wire logic               rst,
  input wire logic               dev_rst,
  // Link and decoded word
  input wire logic               sclk,
  input wire logic               cs_n,
  input wire logic               din,
  input wire logic               ref_enabled,
  input wire logic               two_inputs,
  input wire logic               pin_is_scale,
  input wire logic               pick_second,
  input wire acwd_pkg::acwd_pm_e power_mode,
  input wire logic               powered,
  input wire logic [7:0]         cfg_word
);
  import acwd_pkg::*;
  // Rises wrap every 16-clock frame
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  always_comb begin
    cnt_nxt = dev_rst ? 4'h0 : cnt_r + 4'h1;
    sh_nxt  = (cnt_r < 4'h8) ? {sh_r[6:0], din} : sh_r;
  end
  always_ff @(posedge sclk) begin
    cnt_r <= cnt_nxt;
    sh_r  <= sh_nxt;
  end
  a_ref_bit: assert property (@(posedge sclk) disable iff (dev_rst)
    ref_enabled == !cfg_word[5]) else $error("ref");
  a_input_count: assert property (@(posedge sclk) disable iff (dev_rst)
    two_inputs == cfg_word[4] && pin_is_scale == !cfg_word[4]) else $error("dual");
  a_input_pick: assert property (@(posedge sclk) disable iff (dev_rst)
    pick_second == (cfg_word[4] & cfg_word[3])) else $error("pick");
  a_power_field: assert property (@(posedge sclk) disable iff (dev_rst)
    2'(power_mode) == cfg_word[1:0]) else $error("pm");
  a_power_level: assert property (@(posedge ref_clk) disable iff (rst)
    powered == (power_mode == ACWD_PM_FULL_ON || !cs_n)) else $error("pwr");
  a_word_capture: assert property (@(posedge sclk) disable iff (dev_rst)
    cnt_r == 4'h8 |-> cfg_word == sh_r) else $error("capture");
  a_word_hold: assert property (@(posedge sclk) disable iff (dev_rst)
    cnt_r > 4'h8 |-> $stable(cfg_word)) else $error("hold");
  a_reset_zero: assert property (@(posedge sclk) disable iff (dev_rst)
    $fell(dev_rst) |-> cfg_word == 8'h00) else $error("reset");
endmodule
`default_nettype wire

// ===== test/adc_control_word_decode_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module adc_control_word_decode_tb_top;
  import acwd_pkg::*;
  logic       ref_clk = 1'b0;
  logic       rst     = 1'b1;
  logic       dev_rst = 1'b1;
  logic [1:0] addr    = 2'h0;
  logic [7:0] wdata   = 8'h00;
  logic       wr      = 1'b0;
  logic       rd      = 1'b0;
  logic [7:0] rdata;
  logic [7:0] cfg_word;
  logic       ref_enabled, two_inputs, pin_is_scale, pick_second, powered;
  acwd_pm_e   power_mode;
  int         num_errors   = 0;
  int         total_checks = 0;
  acwd_link_if link ();
  acwd_host i_acwd_host (.ref_clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .link(link));
  acwd_device i_acwd_device (.link(link), .rst(dev_rst), .ref_enabled,
    .two_inputs, .pin_is_scale, .pick_second, .power_mode, .powered,
    .cfg_word);
  acwd_monitor i_acwd_monitor (.ref_clk, .rst, .dev_rst, .sclk(link.sclk),
    .cs_n(link.cs_n), .din(link.din), .ref_enabled, .two_inputs,
    .pin_is_scale, .pick_second, .power_mode, .powered, .cfg_word);
  always #12.5 ref_clk = ~ref_clk;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    @(posedge ref_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task automatic send(input logic [7:0] w);
    int n;
    n = 0;
    bus(1'b1, REG_CMD, w);
    do begin
      bus(1'b0, REG_STATUS, 8'h00);
      n++;
    end while (rdata[0] !== 1'b0 && n < 200);
    if (n >= 200) begin
      num_errors++;
      $display("[ERR] %0t poll limit reached", $time);
    end
  endtask
  // Host cleans the word before it goes out
  function automatic logic [7:0] san(input logic [7:0] w);
    san = w & 8'hBB;
    if (san[4])
      san[5] = 1'b1;
    else
      san[3] = 1'b0;
  endfunction
  task automatic t_word(input logic [7:0] w);
    logic [7:0] e;
    e = san(w);
    send(w);
    check({1'b0, cfg_word[6:0]}, {1'b0, e[6:0]});
    check({ref_enabled, two_inputs, pin_is_scale, pick_second},
      {!e[5], e[4], !e[4], e[4] & e[3]});
    check(8'(power_mode), {6'h0, e[1:0]});
    check({7'h0, powered}, {7'h0, e[1:0] == 2'h1});
    bus(1'b0, REG_LAST, 8'h00);
    check(rdata, e);
    $display("word %h done", w);
  endtask
  task automatic t_busy();
    bus(1'b1, REG_CMD, 8'h01);
    send(8'h02);
    check(cfg_word, 8'h01);
    bus(1'b0, 2'h3, 8'h00);
    check(rdata, 8'h00);
    $display("busy test done");
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    logic [7:0] words [9] = '{8'h00, 8'h01, 8'h02, 8'h03,
                              8'h9E, 8'h5D, 8'h08, 8'h80, 8'h24};
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    // Device reset needs link edges, so a frame runs under it
    send(8'hFF);
    @(posedge ref_clk);
    dev_rst <= 1'b0;
    #1;
    check(cfg_word, CFG_RESET);
    foreach (words[i])
      t_word(words[i]);
    t_busy();
    print_verdict();
  end
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
